// file: design/cws_chip_select_unit.sv
// Chip-select decode and wait-state generation for memory and peripheral regions.
//
// Behaviour
// - Each select asserts for every cycle in its region, whether started by the CPU or the DMA unit.
// - Six memory selects cover three ranges and six peripheral selects serve memory or I/O space.
// - Each peripheral select decodes a 256-byte block at its own offset from one programmable base.
// - Writing a control word enables its decode (midrange, peripheral also need midrange_peripheral_control); blocks 5, 6 are undecoded while carrying A1, A2.
// - Upper and low selects assert with the address at the start of the cycle.
// - The two high peripheral select pins can carry latched address bits A1 and A2 instead.
// - Every region holds one bit saying whether external ready is required or ignored.
// - Upper, low, midrange and the two high peripheral regions take zero to three waits from a two-bit field.
// - The four lowest peripheral selects use a three-bit field adding waits of 5, 7, 9 and 15.
// - With ready required the programmed waits always finish before ready can end or extend the cycle.
// - With two waits and ready required, ready is sampled in the first wait and a ready cycle lasts six clocks.
// - If ready is missing at the sample point the cycle extends until ready, then one more wait precedes the end.
// - The asynchronous ready is active high, may rise at any time and is synchronised inside.
// - After reset the upper select is active over the top of memory with three waits and ready required.
module cws_chip_select_unit (
	input wire logic i_sys_clk, // Processor clock, 250 MHz.
	input wire logic i_reset_n, // Synchronous reset, active low.
	input wire logic i_clk_en, // Clock enable; all state holds while low.
	input wire logic i_cyc_start, // Bus cycle start pulse, taken while idle.
	input wire cws_pkg::cws_req_s i_cyc_req, // Address, space and source of the cycle.
	input wire logic [15:0] i_wr_data, // Control word write data.
	input wire logic i_upper_ctrl_wr, // Write strobe of upper_region_control.
	input wire logic i_low_ctrl_wr, // Write strobe of low_region_control.
	input wire logic i_mid_base_wr, // Write strobe of midrange_base_control.
	input wire logic i_periph_base_wr, // Write strobe of peripheral_base_control.
	input wire logic i_mid_periph_wr, // Write strobe of midrange_peripheral_control.
	input wire logic i_async_ready_in, // Asynchronous ready pin, active high.
	input wire logic i_sync_ready_in, // Synchronous ready pin, active high.
	output logic o_cyc_idle, // High while a new cycle may start.
	output logic o_cyc_done, // One-cycle pulse in the final bus state.
	output logic o_upper_memory_select_n, // Upper memory select, active low.
	output logic o_low_memory_select_n, // Low memory select, active low.
	output logic [3:0] o_midrange_memory_selects_n, // Midrange selects, active low.
	output logic [3:0] o_low_peripheral_selects_n, // Peripheral selects 0 to 3, active low.
	output logic o_peripheral_select_five_n, // Peripheral select 5 or latched A1.
	output logic o_peripheral_select_six_n, // Peripheral select 6 or latched A2.
	output logic [4:0] o_region_enabled // Decode enables: upper, low, mid, periph, addr out.
);

	typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_T3W, ST_T4} cws_state_e;

	cws_state_e state_ff, nxt_state;
	logic [15:0] upper_ctl_ff, low_ctl_ff, mid_base_ff, pbase_ff, midrange_peripheral_control_ff;
	logic en_upper_ff, en_low_ff, en_mbase_ff, en_pbase_ff, en_midrange_peripheral_control_ff;
	cws_pkg::cws_req_s req_ff;
	cws_pkg::cws_sel_s dec_sel, sel_ff;
	logic [4:0] dec_wait, wait_ff;
	logic dec_rdy, rdy_req_ff;
	logic [4:0] cnt_ff;
	logic seen_ff;
	logic [1:0] rdy_level;
	logic ready;
	logic [4:0] samp;
	logic go_t4;
	logic early_ff, late_ff;
	logic a1_ff, a2_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Control words and decode enables.

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			upper_ctl_ff <= cws_pkg::CWS_UPPER_RST;
			low_ctl_ff <= cws_pkg::CWS_LOW_RST;
			mid_base_ff <= cws_pkg::CWS_MID_BASE_RST;
			pbase_ff <= cws_pkg::CWS_PBASE_RST;
			midrange_peripheral_control_ff <= cws_pkg::CWS_MIDRANGE_PERIPHERAL_CONTROL_RST;
		end else if (i_clk_en) begin
			if (i_upper_ctrl_wr)
				upper_ctl_ff <= i_wr_data;
			if (i_low_ctrl_wr)
				low_ctl_ff <= i_wr_data;
			if (i_mid_base_wr)
				mid_base_ff <= i_wr_data;
			if (i_periph_base_wr)
				pbase_ff <= i_wr_data;
			if (i_mid_periph_wr)
				midrange_peripheral_control_ff <= i_wr_data;
		end
	end

	// Upper decode is on from reset; the others turn on once their words are written; blocks 5 and 6 stay undecoded while their pins carry A1 and A2.
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			en_upper_ff <= 1'b1;
			en_low_ff <= 1'b0;
			en_mbase_ff <= 1'b0;
			en_pbase_ff <= 1'b0;
			en_midrange_peripheral_control_ff <= 1'b0;
		end else if (i_clk_en) begin
			if (i_upper_ctrl_wr)
				en_upper_ff <= 1'b1;
			if (i_low_ctrl_wr)
				en_low_ff <= 1'b1;
			if (i_mid_base_wr)
				en_mbase_ff <= 1'b1;
			if (i_periph_base_wr)
				en_pbase_ff <= 1'b1;
			if (i_mid_periph_wr)
				en_midrange_peripheral_control_ff <= 1'b1;
		end
	end

	assign o_region_enabled = {en_upper_ff, en_low_ff, en_mbase_ff & en_midrange_peripheral_control_ff,
		en_pbase_ff & en_midrange_peripheral_control_ff, en_midrange_peripheral_control_ff & midrange_peripheral_control_ff[cws_pkg::CWS_ADDR_OUT_BIT]};

	////////////////////////////////////////////////////////////////////////////////
	// Address decode of the incoming cycle.

	function automatic logic [4:0] ext_wait(input logic [2:0] code);
		logic [4:0] w;
		w = {2'h0, code};
		unique case (code)
			3'h4: w = cws_pkg::CWS_EXT_WAIT4;
			3'h5: w = cws_pkg::CWS_EXT_WAIT5;
			3'h6: w = cws_pkg::CWS_EXT_WAIT6;
			3'h7: w = cws_pkg::CWS_EXT_WAIT7;
			default: w = {2'h0, code};
		endcase
		return w;
	endfunction

	always_comb begin
		logic [19:0] a;
		logic [2:0] k;
		logic [6:0] mb;
		logic [19:0] off;
		logic [2:0] pidx;
		logic [1:0] midx;
		logic mid_hit, p_hit, pmem, aout;
		a = i_cyc_req.addr;
		k = midrange_peripheral_control_ff[cws_pkg::CWS_MSIZE_LSB +: cws_pkg::CWS_MSIZE_W];
		if (k > cws_pkg::CWS_MSIZE_MAX)
			k = cws_pkg::CWS_MSIZE_MAX;
		mb = mid_base_ff[cws_pkg::CWS_MID_BASE_LSB +: cws_pkg::CWS_MID_BASE_W];
		pmem = midrange_peripheral_control_ff[cws_pkg::CWS_PMEM_BIT];
		aout = midrange_peripheral_control_ff[cws_pkg::CWS_ADDR_OUT_BIT];
		off = a - {pbase_ff[cws_pkg::CWS_PBASE_LSB +: cws_pkg::CWS_BOUND_W], 10'h000};
		pidx = off[10:8];
		midx = 2'((a >> (5'd11 + {2'h0, k})) & 20'h00003);
		if (midrange_peripheral_control_ff[cws_pkg::CWS_MALL_BIT])
			midx = 2'h0;
		mid_hit = en_mbase_ff && en_midrange_peripheral_control_ff && !i_cyc_req.io && ((a[19:13] >> k) == (mb >> k));
		p_hit = en_pbase_ff && en_midrange_peripheral_control_ff && (pmem != i_cyc_req.io) && (off < cws_pkg::CWS_PSPAN)
			&& !(aout && pidx >= 3'h5);
		dec_sel = '0;
		dec_wait = '0;
		dec_rdy = 1'b0;
		// Cycles from CPU and DMA decode alike; the source never enters the match.
		if (!i_cyc_req.io && en_upper_ff
			&& a[19:10] >= upper_ctl_ff[cws_pkg::CWS_UPPER_BOUND_LSB +: cws_pkg::CWS_BOUND_W]) begin
			dec_sel.upper = 1'b1;
			dec_wait = {3'h0, upper_ctl_ff[cws_pkg::CWS_WAIT_LSB +: cws_pkg::CWS_WAIT_W]};
			dec_rdy = upper_ctl_ff[cws_pkg::CWS_RDY_BIT];
		end else if (!i_cyc_req.io && en_low_ff
			&& a[19:10] <= low_ctl_ff[cws_pkg::CWS_LOW_TOP_LSB +: cws_pkg::CWS_BOUND_W]) begin
			dec_sel.low = 1'b1;
			dec_wait = {3'h0, low_ctl_ff[cws_pkg::CWS_WAIT_LSB +: cws_pkg::CWS_WAIT_W]};
			dec_rdy = low_ctl_ff[cws_pkg::CWS_RDY_BIT];
		end else if (mid_hit) begin
			dec_sel.mid[midx] = 1'b1;
			dec_wait = {3'h0, mid_base_ff[cws_pkg::CWS_WAIT_LSB +: cws_pkg::CWS_WAIT_W]};
			dec_rdy = mid_base_ff[cws_pkg::CWS_RDY_BIT];
		end else if (p_hit) begin
			dec_sel.periph[pidx] = 1'b1;
			if (pidx >= 3'h5) begin
				dec_wait = {3'h0, midrange_peripheral_control_ff[cws_pkg::CWS_WAIT_LSB +: cws_pkg::CWS_WAIT_W]};
				dec_rdy = midrange_peripheral_control_ff[cws_pkg::CWS_RDY_BIT];
			end else begin
				dec_wait = ext_wait(pbase_ff[cws_pkg::CWS_PWAIT_LSB +: cws_pkg::CWS_PWAIT_W]);
				dec_rdy = pbase_ff[cws_pkg::CWS_PRDY_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Ready inputs.

	cws_pin_sync #(
		.WIDTH(2),
		.STAGES(cws_pkg::CWS_SYNC_STAGES)
	) u_rdy_sync (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_clk_en(i_clk_en),
		.i_pin({i_sync_ready_in, i_async_ready_in}),
		.o_level(rdy_level)
	);

	// A late drop of the asynchronous ready is only seen after the filter; the far side times it.
	assign ready = rdy_level[0] | rdy_level[1];

	////////////////////////////////////////////////////////////////////////////////
	// Bus cycle sequence.

	assign samp = (wait_ff == 5'h00) ? 5'h00 : wait_ff - 5'h01;

	always_comb begin
		if (!rdy_req_ff)
			go_t4 = (cnt_ff == wait_ff);
		else if (seen_ff)
			go_t4 = 1'b1;
		else
			go_t4 = ready && (wait_ff == 5'h00) && (cnt_ff == 5'h00);
	end

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: if (i_cyc_start) nxt_state = ST_T1;
			ST_T1: nxt_state = ST_T2;
			ST_T2: nxt_state = ST_T3W;
			ST_T3W: if (go_t4) nxt_state = ST_T4;
			ST_T4: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			state_ff <= ST_IDLE;
		end else if (i_clk_en) begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			req_ff <= '0;
			sel_ff <= '0;
			wait_ff <= '0;
			rdy_req_ff <= 1'b0;
		end else if (i_clk_en && state_ff == ST_IDLE && i_cyc_start) begin
			req_ff <= i_cyc_req;
			sel_ff <= dec_sel;
			wait_ff <= dec_wait;
			rdy_req_ff <= dec_rdy;
		end
	end

	// Count of clocks spent since entering T3; the sample point is one before the last wait.
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			cnt_ff <= '0;
			seen_ff <= 1'b0;
		end else if (i_clk_en) begin
			if (state_ff != ST_T3W) begin
				cnt_ff <= '0;
				seen_ff <= 1'b0;
			end else begin
				if (cnt_ff != 5'h1F)
					cnt_ff <= cnt_ff + 5'h01;
				if (rdy_req_ff && !go_t4 && ready && cnt_ff >= samp)
					seen_ff <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Select pins.

	// Upper and low selects fall with the address in T1; the others one clock later.
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			early_ff <= 1'b0;
			late_ff <= 1'b0;
		end else if (i_clk_en) begin
			if (state_ff == ST_IDLE && i_cyc_start)
				early_ff <= 1'b1;
			else if (state_ff == ST_T4)
				early_ff <= 1'b0;
			if (state_ff == ST_T1)
				late_ff <= 1'b1;
			else if (state_ff == ST_T4)
				late_ff <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			a1_ff <= 1'b0;
			a2_ff <= 1'b0;
		end else if (i_clk_en && state_ff == ST_IDLE && i_cyc_start) begin
			a1_ff <= i_cyc_req.addr[1];
			a2_ff <= i_cyc_req.addr[2];
		end
	end

	always_comb begin
		logic aout;
		aout = en_midrange_peripheral_control_ff && midrange_peripheral_control_ff[cws_pkg::CWS_ADDR_OUT_BIT];
		o_upper_memory_select_n = ~(early_ff & sel_ff.upper);
		o_low_memory_select_n = ~(early_ff & sel_ff.low);
		o_midrange_memory_selects_n = ~(sel_ff.mid & {4{late_ff}});
		o_low_peripheral_selects_n = ~(sel_ff.periph[3:0] & {4{late_ff}});
		o_peripheral_select_five_n = aout ? a1_ff : ~(late_ff & sel_ff.periph[5]);
		o_peripheral_select_six_n = aout ? a2_ff : ~(late_ff & sel_ff.periph[6]);
	end

	assign o_cyc_idle = (state_ff == ST_IDLE);
	assign o_cyc_done = (state_ff == ST_T4);

endmodule

// file: design/cws_pin_sync.sv
// Multi-bit pin synchroniser with a two-stage agreement filter.
module cws_pin_sync #(
	parameter int unsigned WIDTH = 2,
	parameter int unsigned STAGES = cws_pkg::CWS_SYNC_STAGES
) (
	input wire logic i_sys_clk, // Processor clock.
	input wire logic i_reset_n, // Synchronous reset, active low.
	input wire logic i_clk_en, // Freezes all state while low.
	input wire logic [WIDTH-1:0] i_pin, // Asynchronous pin levels.
	output logic [WIDTH-1:0] o_level // Filtered synchronous levels.
);

	// Fewer than three stages would leave no agreement pair behind the first flop.
	if (STAGES < 3) begin : g_bad_stages
		$error("cws_pin_sync needs at least three stages");
	end

	for (genvar b = 0; b < WIDTH; b++) begin : g_bit
		logic [STAGES-1:0] chain_ff;
		logic level_ff;

		always_ff @(posedge i_sys_clk) begin
			if (!i_reset_n) begin
				chain_ff <= '0;
			end else if (i_clk_en) begin
				chain_ff <= {chain_ff[STAGES-2:0], i_pin[b]};
			end
		end

		// A change counts only once the last two stages agree.
		always_ff @(posedge i_sys_clk) begin
			if (!i_reset_n) begin
				level_ff <= 1'b0;
			end else if (i_clk_en && (chain_ff[STAGES-1] == chain_ff[STAGES-2])) begin
				level_ff <= chain_ff[STAGES-1];
			end
		end

		assign o_level[b] = level_ff;
	end

endmodule

// file: design/cws_pkg.sv
// Constants, field layouts and carrier types of the chip-select and wait-state unit.
package cws_pkg;

	localparam int unsigned CWS_ADDR_W = 20;
	localparam int unsigned CWS_CTRL_W = 16;

	// Common fields of the region control words.
	localparam int unsigned CWS_WAIT_LSB = 0;
	localparam int unsigned CWS_WAIT_W = 2;
	localparam int unsigned CWS_RDY_BIT = 2;

	// Upper region control: lower boundary on address bits 19..10.
	localparam int unsigned CWS_UPPER_BOUND_LSB = 6;
	localparam int unsigned CWS_BOUND_W = 10;
	// Low region control: top boundary on address bits 19..10.
	localparam int unsigned CWS_LOW_TOP_LSB = 6;
	// Midrange base control: base on address bits 19..13.
	localparam int unsigned CWS_MID_BASE_LSB = 9;
	localparam int unsigned CWS_MID_BASE_W = 7;
	// Peripheral base control: base on address bits 19..10, three-bit wait field, ready bit.
	localparam int unsigned CWS_PBASE_LSB = 6;
	localparam int unsigned CWS_PWAIT_LSB = 0;
	localparam int unsigned CWS_PWAIT_W = 3;
	localparam int unsigned CWS_PRDY_BIT = 3;
	// Midrange and peripheral control: block size code, modes, wait and ready of the two high selects.
	localparam int unsigned CWS_MSIZE_LSB = 8;
	localparam int unsigned CWS_MSIZE_W = 3;
	localparam int unsigned CWS_MALL_BIT = 7;
	localparam int unsigned CWS_PMEM_BIT = 6;
	localparam int unsigned CWS_ADDR_OUT_BIT = 5;

	// Reset values: upper region from F0000h, ready required, three wait states.
	localparam logic [15:0] CWS_UPPER_RST = 16'hF007;
	localparam logic [15:0] CWS_LOW_RST = 16'h0007;
	localparam logic [15:0] CWS_MID_BASE_RST = 16'h0007;
	localparam logic [15:0] CWS_PBASE_RST = 16'h000F;
	localparam logic [15:0] CWS_MIDRANGE_PERIPHERAL_CONTROL_RST = 16'h0007;

	// Peripheral blocks: seven of 256 bytes each above the base.
	localparam int unsigned CWS_PBLOCKS = 7;
	localparam logic [19:0] CWS_PSPAN = 20'h00700;
	localparam logic [2:0] CWS_MSIZE_MAX = 3'h6;

	// Extended wait counts of the three-bit field, codes 4 to 7.
	localparam logic [4:0] CWS_EXT_WAIT4 = 5'h05;
	localparam logic [4:0] CWS_EXT_WAIT5 = 5'h07;
	localparam logic [4:0] CWS_EXT_WAIT6 = 5'h09;
	localparam logic [4:0] CWS_EXT_WAIT7 = 5'h0F;

	localparam int unsigned CWS_SYNC_STAGES = 3;

	typedef struct packed {
		logic [19:0] addr;
		logic io;
		logic dma;
	} cws_req_s;

	typedef struct packed {
		logic upper;
		logic low;
		logic [3:0] mid;
		logic [6:0] periph;
	} cws_sel_s;

endpackage

// file: tb/cws_chip_select_unit_tb.sv
// Self-checking testbench of the chip-select and wait-state unit.
module cws_chip_select_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk, i_reset_n, i_cyc_start, use_sync, i_async_ready_in, i_sync_ready_in, clk_en;
	logic o_cyc_idle, o_cyc_done, up_n, low_n, p5_n, p6_n;
	logic [3:0] mid_n, per_n;
	logic [4:0] o_region_enabled, wr;
	logic [7:0] delay;
	logic [11:0] snap;
	logic [15:0] i_wr_data;
	cws_pkg::cws_req_s i_cyc_req;
	int errors, checks, len;
	int ext[4] = '{5, 7, 9, 15};

	cws_chip_select_unit cws_chip_select_unit_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
		.i_clk_en(clk_en), .i_cyc_start(i_cyc_start), .i_cyc_req(i_cyc_req), .i_wr_data(i_wr_data),
		.i_upper_ctrl_wr(wr[4]), .i_low_ctrl_wr(wr[3]), .i_mid_base_wr(wr[2]), .i_periph_base_wr(wr[1]),
		.i_mid_periph_wr(wr[0]), .i_async_ready_in(i_async_ready_in), .i_sync_ready_in(i_sync_ready_in),
		.o_cyc_idle(o_cyc_idle), .o_cyc_done(o_cyc_done), .o_upper_memory_select_n(up_n),
		.o_low_memory_select_n(low_n), .o_midrange_memory_selects_n(mid_n), .o_low_peripheral_selects_n(per_n),
		.o_peripheral_select_five_n(p5_n), .o_peripheral_select_six_n(p6_n), .o_region_enabled(o_region_enabled));
	cws_far_side cws_far_side_inst (.i_sys_clk(i_sys_clk), .i_selected(!up_n || !low_n || ~&mid_n || ~&per_n),
		.i_delay(delay), .i_use_sync(use_sync), .o_async_ready_in(i_async_ready_in),
		.o_sync_ready_in(i_sync_ready_in));

	initial begin
		i_sys_clk = 1'h0;
		forever #2 i_sys_clk = ~i_sys_clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic wr_ctrl(input logic [4:0] m, input logic [15:0] data);
		@(negedge i_sys_clk);
		wr = m;
		i_wr_data = data;
		@(negedge i_sys_clk);
		wr = 5'h00;
	endtask
	task automatic cyc(input logic [19:0] a, input logic io, input logic dma);
		@(negedge i_sys_clk);
		i_cyc_req = '{a, io, dma};
		i_cyc_start = 1'h1;
		@(negedge i_sys_clk);
		i_cyc_start = 1'h0;
		// This falling edge already lies in T1, so len ends as the number of bus states.
		len = 1;
		do begin
			@(negedge i_sys_clk);
			len++;
		end while (o_cyc_done !== 1'h1 && len < 200);
		snap = {up_n, low_n, mid_n, per_n, p5_n, p6_n};
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		errors++;
		tally_and_finish();
	end
	initial begin
		i_reset_n = 1'h0;
		i_cyc_start = 1'h0;
		i_cyc_req = '0;
		i_wr_data = 16'h0000;
		wr = 5'h00;
		delay = 8'h00;
		use_sync = 1'h0;
		clk_en = 1'h1;
		repeat (2) @(negedge i_sys_clk);
		chk(o_region_enabled, 5'h10);
		chk({o_cyc_idle, o_cyc_done}, 2'h2);
		i_reset_n = 1'h1;
		cyc(20'hFFFF0, 1'h0, 1'h0);
		chk(len, 7);
		chk(snap, 12'h7FF);
		$display("test reset fetch done");
		delay = 8'hFF;
		for (int n = 0; n < 4; n++) begin
			wr_ctrl(5'h10, 16'hF000 | n[15:0]);
			cyc(20'hF1234, 1'h0, n[0]);
			chk(len, 4 + n);
			chk(snap[11], 1'h0);
		end
		// Three frozen clocks inside T2 must lengthen a three-wait cycle by exactly three.
		fork
			cyc(20'hF1234, 1'h0, 1'h0);
			begin
				repeat (3) @(negedge i_sys_clk);
				clk_en = 1'h0;
				repeat (3) @(negedge i_sys_clk);
				clk_en = 1'h1;
			end
		join
		chk(len, 10);
		$display("test wait states done");
		wr_ctrl(5'h10, 16'hF006);
		delay = 8'h00;
		cyc(20'hFFFF0, 1'h0, 1'h0);
		chk(len, 6);
		delay = 8'h0C;
		repeat (6) @(negedge i_sys_clk);
		cyc(20'hFFFF0, 1'h0, 1'h1);
		chk(len >= 17 && len <= 23, 1);
		delay = 8'hFF;
		use_sync = 1'h1;
		repeat (6) @(negedge i_sys_clk);
		cyc(20'hFFFF0, 1'h0, 1'h0);
		chk(len, 6);
		use_sync = 1'h0;
		$display("test ready done");
		// Ready stands high from here on, so regions without ready must not end early.
		delay = 8'h00;
		wr_ctrl(5'h04, 16'h2001);
		wr_ctrl(5'h01, 16'h0080);
		chk(o_region_enabled, 5'h14);
		cyc(20'h20010, 1'h0, 1'h1);
		chk(len, 5);
		chk(snap[9:6], 4'hE);
		for (int k = 0; k < 4; k++) begin
			wr_ctrl(5'h02, 16'h0044 | k[15:0]);
			chk(o_region_enabled, 5'h16);
			cyc(20'h00400 + 20'h00100 * k[19:0], 1'h1, k[0]);
			chk(len, 4 + ext[k]);
			chk(snap[5:2], 4'(~(4'h1 << k)));
		end
		$display("test peripheral blocks done");
		wr_ctrl(5'h01, 16'h00A0);
		chk(o_region_enabled, 5'h17);
		cyc(20'h00402, 1'h1, 1'h0);
		chk(snap[1:0], 2'h2);
		$display("test address out done");
		i_reset_n = 1'h0;
		repeat (2) @(negedge i_sys_clk);
		i_reset_n = 1'h1;
		chk(o_region_enabled, 5'h10);
		cyc(20'hFFFF0, 1'h0, 1'h0);
		chk(len, 7);
		chk(snap, 12'h7FF);
		$display("test second reset done");
		tally_and_finish();
	end
endmodule

// file: tb/cws_far_side.sv
// Model of the memories and peripherals that answer with ready.
module cws_far_side (
	input wire logic i_sys_clk, // Clock.
	input wire logic i_selected, // Upper, low, a midrange or a peripheral 0 to 3 select is low.
	input wire logic [7:0] i_delay, // Cycles to ready; zero holds ready high.
	input wire logic i_use_sync, // Answer on the synchronous pin.
	output logic o_async_ready_in, // Asynchronous ready.
	output logic o_sync_ready_in // Synchronous ready.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt;
	initial begin
		cnt = 8'h00;
		o_async_ready_in = 1'h0;
		o_sync_ready_in = 1'h0;
	end
	always @(posedge i_sys_clk) begin
		cnt <= i_selected ? cnt + 8'h01 : 8'h00;
		o_sync_ready_in <= i_use_sync;
		if (!i_selected && i_delay != 8'h00) begin
			o_async_ready_in <= 1'h0;
		end
		if ((i_selected && cnt >= i_delay) || i_delay == 8'h00) begin
			// The rising edge lands off the clock grid on purpose.
			#1.3 o_async_ready_in = 1'h1;
		end
	end
endmodule

// file: tb/cws_monitor.sv
// Port checker of the chip-select and wait-state unit.
module cws_monitor (
	input wire logic i_sys_clk, // Clock.
	input wire logic i_reset_n, // Reset, active low.
	input wire logic i_clk_en, // Clock enable.
	input wire logic i_cyc_start, // Cycle start.
	input wire logic o_cyc_idle, // Idle.
	input wire logic o_cyc_done, // Final state.
	input wire logic o_upper_memory_select_n, // Upper select.
	input wire logic o_low_memory_select_n, // Low select.
	input wire logic [3:0] o_midrange_memory_selects_n, // Midrange selects.
	input wire logic [3:0] o_low_peripheral_selects_n, // Peripheral selects.
	input wire logic [4:0] o_region_enabled // Decode enables.
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_reset_n);
	logic take;
	logic [9:0] sel_n;
	assign take = o_cyc_idle && i_cyc_start && i_clk_en;
	assign sel_n = {o_upper_memory_select_n, o_low_memory_select_n, o_midrange_memory_selects_n,
		o_low_peripheral_selects_n};
	reset_state_a: assert property (disable iff (1'h0) !i_reset_n && i_clk_en |=>
		o_region_enabled == 5'h10 && o_cyc_idle && &sel_n) else $error("state after reset wrong");
	done_pulse_a: assert property (o_cyc_done && i_clk_en |=> !o_cyc_done && o_cyc_idle)
		else $error("final state not one cycle");
	start_taken_a: assert property (take |=> !o_cyc_idle) else $error("start not taken");
	min_waits_a: assert property (take |=> !o_cyc_done [*3]) else $error("cycle too short");
	idle_quiet_a: assert property (o_cyc_idle |-> &sel_n) else $error("select low while idle");
	one_select_a: assert property ($onehot0(~sel_n)) else $error("two selects low");
	upper_hold_a: assert property (!o_upper_memory_select_n && !o_cyc_done |=> !o_upper_memory_select_n)
		else $error("upper select dropped early");
	upper_cycle_a: assert property (!o_upper_memory_select_n |-> !o_cyc_idle)
		else $error("upper select outside cycle");
	cover property (take);
	cover property (o_cyc_done && !o_upper_memory_select_n);
	cover property (o_cyc_done && o_low_peripheral_selects_n != 4'hF);
endmodule
bind cws_chip_select_unit cws_monitor cws_monitor_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
	.i_clk_en(i_clk_en), .i_cyc_start(i_cyc_start), .o_cyc_idle(o_cyc_idle), .o_cyc_done(o_cyc_done),
	.o_upper_memory_select_n(o_upper_memory_select_n), .o_low_memory_select_n(o_low_memory_select_n),
	.o_midrange_memory_selects_n(o_midrange_memory_selects_n),
	.o_low_peripheral_selects_n(o_low_peripheral_selects_n), .o_region_enabled(o_region_enabled));
